// >>> verilog/fwr_defines.svh
// Purpose : constants of the fault waveform recorder
// Assumes : 100 MHz clock, 50 Hz power system, settings in 10 ms units
// Notes   : times scale by sixteen in r.m.s. mode
//
// Contract
// - instantaneous mode stores every sample, 1.25 ms apart, sixteen per cycle
// - instantaneous record stops at set length, never beyond five seconds
// - r.m.s. mode stores one value per half cycle, record at most 80 s
// - at most eight records kept, new faults overwrite without acknowledgement
// - start by pickup, binary input, operator or serial command
// - transfer request raised after every record or only after trip
// - recording disabled unless type is instantaneous or r.m.s.
// - trigger selection: save on pickup (default), save on trip, start on trip
// - with pickup triggering the pickup instant is time zero
// - record starts pre-time before zero, ends post-time after criterion drops
// - maximum length 0.30 to 5.00 s, default 1.00 s
// - pre-trigger time 0.05 to 4.00 s, default 0.20 s
// - post-record time 0.05 to 0.50 s, default 0.10 s
// - in r.m.s. mode all setting durations are sixteen times longer
// - binary or command trigger acts on edge, length from capture window
// - capture window 0.10 to 5.00 s or infinite, default 0.50 s
// - infinite window lasts while input active, capped by maximum length
// - running output while capturing, event when stored data are deleted
`ifndef FWR_DEFINES_SVH
`define FWR_DEFINES_SVH

// -----------------------------------------------------------------
// timing
// -----------------------------------------------------------------
`define FWR_CLK_PERIOD_NS    10
`define FWR_SAMPLE_PERIOD_US 1250
`define FWR_INST_UNIT_LAST   7'h07
`define FWR_RMS_UNIT_LAST    7'h7F
`define FWR_RMS_STRIDE_LAST  3'h7
`define FWR_INST_UNIT_SHIFT  4'h3
`define FWR_RMS_UNIT_SHIFT   4'h4

// -----------------------------------------------------------------
// register offsets
// -----------------------------------------------------------------
`define FWR_OFS_CTRL    8'h00
`define FWR_OFS_MAXLEN  8'h04
`define FWR_OFS_PRE     8'h08
`define FWR_OFS_POST    8'h0C
`define FWR_OFS_CAPT    8'h10
`define FWR_OFS_STATUS  8'h14
`define FWR_OFS_SLOTSEL 8'h18
`define FWR_OFS_DESC    8'h1C

// -----------------------------------------------------------------
// control fields
// -----------------------------------------------------------------
`define FWR_CTRL_TYPE_LSB  0
`define FWR_CTRL_TRIG_LSB  2
`define FWR_CTRL_XFER_EN   4
`define FWR_CTRL_XFER_TRIP 5
`define FWR_CTRL_START     8

// -----------------------------------------------------------------
// settings, 10 ms units
// -----------------------------------------------------------------
`define FWR_MAXLEN_MIN 10'h01E
`define FWR_MAXLEN_MAX 10'h1F4
`define FWR_MAXLEN_DEF 10'h064
`define FWR_PRE_MIN    10'h005
`define FWR_PRE_MAX    10'h190
`define FWR_PRE_DEF    10'h014
`define FWR_POST_MIN   10'h005
`define FWR_POST_MAX   10'h032
`define FWR_POST_DEF   10'h00A
`define FWR_CAPT_MIN   10'h00A
`define FWR_CAPT_MAX   10'h1F4
`define FWR_CAPT_DEF   10'h032
`define FWR_CAPT_INF   10'h000
`define FWR_NUM_SLOTS  4'h8

`endif

// >>> verilog/fwr_pkg.sv
// Purpose : types of the fault waveform recorder
// Assumes : nothing
// Notes   : enum order gives the register field encoding
package fwr_pkg;
    typedef enum logic [1:0] {FWR_REC_OFF, FWR_REC_INST, FWR_REC_RMS, FWR_REC_RSVD} fwr_rec_e;
    typedef enum logic [1:0] {FWR_SAVE_PICKUP, FWR_SAVE_TRIP, FWR_START_TRIP,
                              FWR_TRIG_RSVD} fwr_trig_e;
    typedef enum logic [1:0] {FWR_ST_IDLE, FWR_ST_HOLD, FWR_ST_POST, FWR_ST_STORE} fwr_state_e;
endpackage

// >>> verilog/fwr_pin_sync.sv
// Purpose : three-stage synchroniser for a pin input
// Assumes : input asynchronous to clk
// Notes   : level updates once stages two and three agree
`timescale 1ns/10ps
module fwr_pin_sync (
    input  wire logic clk,
    input  wire logic resetn,
    input  wire logic pinIn,
    output logic      levelOut
);
    logic s1_q;
    logic s2_q;
    logic s3_q;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            s1_q     <= 1'b0;
            s2_q     <= 1'b0;
            s3_q     <= 1'b0;
            levelOut <= 1'b0;
        end else begin
            s1_q <= pinIn;
            s2_q <= s1_q;
            s3_q <= s2_q;
            if (s2_q == s3_q) begin
                levelOut <= s3_q;
            end
        end
    end
endmodule

// >>> verilog/fwr_skid_buffer.sv
// Purpose : two-entry buffer with valid and ready on both sides
// Assumes : single clock
// Notes   : inReady drops while the spare entry is used
`timescale 1ns/10ps
module fwr_skid_buffer #(
    parameter int WIDTH = 32
) (
    input  wire logic             clk,
    input  wire logic             resetn,
    input  wire logic             inValid,
    input  wire logic [WIDTH-1:0] inData,
    output logic                  inReady,
    output logic                  outValid,
    output logic      [WIDTH-1:0] outData,
    input  wire logic             outReady
);
    logic [WIDTH-1:0] skid_q;
    logic             skidValid_q;
    wire              push = inValid & inReady;
    wire              advance = outReady | ~outValid;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            outValid    <= 1'b0;
            outData     <= '0;
            skid_q      <= '0;
            skidValid_q <= 1'b0;
        end else if (advance) begin
            outValid    <= skidValid_q | push;
            outData     <= skidValid_q ? skid_q : inData;
            skidValid_q <= 1'b0;
        end else if (push) begin
            skid_q      <= inData;
            skidValid_q <= 1'b1;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            inReady <= 1'b0;
        end else begin
            inReady <= advance | ~(skidValid_q | push);
        end
    end
endmodule

// >>> verilog/fwr_recorder.sv
// Purpose : fault waveform recorder with APB settings and ring write stream
// Assumes : sampleIn from same-clock logic; ring memory outside
// Notes   : descriptors hold start and end ring addresses of up to eight records
`timescale 1ns/10ps
`include "fwr_defines.svh"
module fwr_recorder import fwr_pkg::*; #(
    parameter int SAMPLE_CYC = `FWR_SAMPLE_PERIOD_US * 1000 / `FWR_CLK_PERIOD_NS
) (
    input  wire logic        clk,
    input  wire logic        resetn,
    input  wire logic [7:0]  paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        protPickup,
    input  wire logic        protTrip,
    input  wire logic        binTrigPin,
    input  wire logic [15:0] sampleIn,
    output logic      [15:0] memAddr,
    output logic      [15:0] memData,
    output logic             memValid,
    input  wire logic        memReady,
    output logic             recRunning,
    output logic             wavesDeleted,
    output logic             xferReq
);
    // -----------------------------------------------------------------
    // helpers
    // -----------------------------------------------------------------
    function automatic logic [9:0] clampSet(input logic [9:0] v, input logic [9:0] lo,
                                            input logic [9:0] hi);
        clampSet = (v < lo) ? lo : ((v > hi) ? hi : v);
    endfunction

    // -----------------------------------------------------------------
    // settings and APB slave
    // -----------------------------------------------------------------
    fwr_rec_e    recType_q;
    fwr_trig_e   trigSel_q;
    logic        xferEn_q;
    logic        xferTripOnly_q;
    logic [9:0]  maxLen_q;
    logic [9:0]  preTime_q;
    logic [9:0]  postTime_q;
    logic [9:0]  captTime_q;
    logic [2:0]  slotSel_q;
    logic        startCmd_q;
    logic [31:0] desc_q [8];
    logic [2:0]  wrSlot_q;
    logic [3:0]  recCount_q;
    logic [15:0] wp_q;
    fwr_state_e  state_q;
    fwr_state_e  state_d;

    wire        setup   = psel & ~penable;
    wire        access  = psel & penable & pready;
    wire        wrEn    = access & pwrite;
    wire        hitCtrl = paddr == `FWR_OFS_CTRL;
    wire        hitMax  = paddr == `FWR_OFS_MAXLEN;
    wire        hitPre  = paddr == `FWR_OFS_PRE;
    wire        hitPost = paddr == `FWR_OFS_POST;
    wire        hitCapt = paddr == `FWR_OFS_CAPT;
    wire        hitStat = paddr == `FWR_OFS_STATUS;
    wire        hitSel  = paddr == `FWR_OFS_SLOTSEL;
    wire        hitDesc = paddr == `FWR_OFS_DESC;
    wire        addrHit = hitCtrl | hitMax | hitPre | hitPost | hitCapt | hitStat
                        | hitSel | hitDesc;
    wire [31:0] ctrlRd  = {26'h0, xferTripOnly_q, xferEn_q, trigSel_q, recType_q};
    wire [31:0] statRd  = {5'h00, wrSlot_q, wp_q, recCount_q, 3'h0, recRunning};
    wire [31:0] rdMux   = hitCtrl ? ctrlRd
                        : hitMax  ? {22'h0, maxLen_q}
                        : hitPre  ? {22'h0, preTime_q}
                        : hitPost ? {22'h0, postTime_q}
                        : hitCapt ? {22'h0, captTime_q}
                        : hitStat ? statRd
                        : hitSel  ? {29'h0, slotSel_q}
                        : hitDesc ? desc_q[slotSel_q]
                        : 32'h0;
    wire [9:0]  wrVal   = pwdata[9:0];
    wire [9:0]  captNew = (wrVal == `FWR_CAPT_INF) ? `FWR_CAPT_INF
                        : clampSet(wrVal, `FWR_CAPT_MIN, `FWR_CAPT_MAX);

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0;
        end else begin
            pready  <= setup;
            pslverr <= setup & ~addrHit;
            prdata  <= (setup & ~pwrite) ? rdMux : 32'h0;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            recType_q      <= FWR_REC_OFF;
            trigSel_q      <= FWR_SAVE_PICKUP;
            xferEn_q       <= 1'b0;
            xferTripOnly_q <= 1'b0;
            startCmd_q     <= 1'b0;
        end else begin
            startCmd_q <= wrEn & hitCtrl & pwdata[`FWR_CTRL_START];
            if (wrEn && hitCtrl) begin
                recType_q      <= fwr_rec_e'(pwdata[`FWR_CTRL_TYPE_LSB +: 2]);
                trigSel_q      <= fwr_trig_e'(pwdata[`FWR_CTRL_TRIG_LSB +: 2]);
                xferEn_q       <= pwdata[`FWR_CTRL_XFER_EN];
                xferTripOnly_q <= pwdata[`FWR_CTRL_XFER_TRIP];
            end
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            maxLen_q   <= `FWR_MAXLEN_DEF;
            preTime_q  <= `FWR_PRE_DEF;
            postTime_q <= `FWR_POST_DEF;
            captTime_q <= `FWR_CAPT_DEF;
            slotSel_q  <= 3'h0;
        end else if (wrEn) begin
            if (hitMax) begin
                maxLen_q <= clampSet(wrVal, `FWR_MAXLEN_MIN, `FWR_MAXLEN_MAX);
            end
            if (hitPre) begin
                preTime_q <= clampSet(wrVal, `FWR_PRE_MIN, `FWR_PRE_MAX);
            end
            if (hitPost) begin
                postTime_q <= clampSet(wrVal, `FWR_POST_MIN, `FWR_POST_MAX);
            end
            if (hitCapt) begin
                captTime_q <= captNew;
            end
            if (hitSel) begin
                slotSel_q <= pwdata[2:0];
            end
        end
    end

    // -----------------------------------------------------------------
    // sample timing
    // -----------------------------------------------------------------
    logic [16:0] divCnt_q;
    logic [6:0]  subCnt_q;
    wire         enabled    = (recType_q == FWR_REC_INST) | (recType_q == FWR_REC_RMS);
    wire         rmsMode    = recType_q == FWR_REC_RMS;
    wire         sampleTick = divCnt_q == 17'(SAMPLE_CYC - 1);
    wire         storeTick  = sampleTick & enabled
                            & (~rmsMode | (subCnt_q[2:0] == `FWR_RMS_STRIDE_LAST));
    wire [6:0]   unitLast   = rmsMode ? `FWR_RMS_UNIT_LAST : `FWR_INST_UNIT_LAST;
    wire         unitTick   = sampleTick & ((subCnt_q & unitLast) == unitLast);

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            divCnt_q <= 17'h0;
            subCnt_q <= 7'h0;
        end else begin
            divCnt_q <= sampleTick ? 17'h0 : divCnt_q + 17'h1;
            if (sampleTick) begin
                subCnt_q <= subCnt_q + 7'h1;
            end
        end
    end

    // -----------------------------------------------------------------
    // ring write stream
    // -----------------------------------------------------------------
    logic        pend_q;
    logic [15:0] pendData_q;
    logic        bufInReady;
    wire         push = pend_q & bufInReady;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            pend_q     <= 1'b0;
            pendData_q <= 16'h0;
            wp_q       <= 16'h0;
        end else begin
            pend_q <= storeTick | (pend_q & ~bufInReady);
            if (storeTick) begin
                pendData_q <= sampleIn;
            end
            if (push) begin
                wp_q <= wp_q + 16'h1;
            end
        end
    end

    fwr_skid_buffer #(
        .WIDTH (32)
    ) u_buf (
        .clk      (clk),
        .resetn   (resetn),
        .inValid  (pend_q),
        .inData   ({wp_q, pendData_q}),
        .inReady  (bufInReady),
        .outValid (memValid),
        .outData  ({memAddr, memData}),
        .outReady (memReady)
    );

    // -----------------------------------------------------------------
    // trigger sources
    // -----------------------------------------------------------------
    logic binLvl;
    logic binPrev_q;
    logic pickPrev_q;
    logic tripPrev_q;

    fwr_pin_sync u_binsync (
        .clk      (clk),
        .resetn   (resetn),
        .pinIn    (binTrigPin),
        .levelOut (binLvl)
    );

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            binPrev_q  <= 1'b0;
            pickPrev_q <= 1'b0;
            tripPrev_q <= 1'b0;
        end else begin
            binPrev_q  <= binLvl;
            pickPrev_q <= protPickup;
            tripPrev_q <= protTrip;
        end
    end

    wire tripMode = trigSel_q == FWR_START_TRIP;
    wire protTrig = tripMode ? (protTrip & ~tripPrev_q) : (protPickup & ~pickPrev_q);
    wire manTrig  = (binLvl & ~binPrev_q) | startCmd_q;

    // -----------------------------------------------------------------
    // record sequencer
    // -----------------------------------------------------------------
    logic        manual_q;
    logic        sawTrip_q;
    logic [9:0]  lenCnt_q;
    logic [9:0]  postCnt_q;
    logic [15:0] startAddr_q;

    wire [3:0]  preShift = rmsMode ? `FWR_RMS_UNIT_SHIFT : `FWR_INST_UNIT_SHIFT;
    wire [15:0] preWords = 16'({6'h00, preTime_q} << preShift);
    wire        lenCap   = lenCnt_q >= maxLen_q;
    wire        captInf  = captTime_q == `FWR_CAPT_INF;
    wire        manCrit  = captInf ? binLvl : (lenCnt_q < captTime_q);
    wire        protCrit = tripMode ? protTrip : protPickup;
    wire        crit     = manual_q ? manCrit : protCrit;
    wire        postDone = postCnt_q >= postTime_q;
    wire        saveRec  = manual_q | (trigSel_q != FWR_SAVE_TRIP) | sawTrip_q;
    wire        slotFull = recCount_q == `FWR_NUM_SLOTS;

    always_comb begin
        state_d = state_q;
        case (state_q)
            FWR_ST_IDLE: begin
                if (enabled && (protTrig || manTrig)) begin
                    state_d = FWR_ST_HOLD;
                end
            end
            FWR_ST_HOLD: begin
                if (!crit || lenCap) begin
                    state_d = FWR_ST_POST;
                end
            end
            FWR_ST_POST: begin
                if (postDone || lenCap) begin
                    state_d = FWR_ST_STORE;
                end
            end
            FWR_ST_STORE: begin
                state_d = FWR_ST_IDLE;
            end
            default: begin
                state_d = FWR_ST_IDLE;
            end
        endcase
        if (!enabled) begin
            state_d = FWR_ST_IDLE;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state_q    <= FWR_ST_IDLE;
            recRunning <= 1'b0;
        end else begin
            state_q    <= state_d;
            recRunning <= state_d != FWR_ST_IDLE;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            manual_q    <= 1'b0;
            sawTrip_q   <= 1'b0;
            lenCnt_q    <= 10'h0;
            postCnt_q   <= 10'h0;
            startAddr_q <= 16'h0;
        end else if (state_q == FWR_ST_IDLE) begin
            manual_q    <= ~protTrig;
            sawTrip_q   <= protTrip;
            lenCnt_q    <= 10'h0;
            postCnt_q   <= 10'h0;
            startAddr_q <= wp_q - preWords;
        end else begin
            sawTrip_q <= sawTrip_q | protTrip;
            if (unitTick && !lenCap) begin
                lenCnt_q <= lenCnt_q + 10'h1;
            end
            if (unitTick && state_q == FWR_ST_POST) begin
                postCnt_q <= postCnt_q + 10'h1;
            end
        end
    end

    // -----------------------------------------------------------------
    // record slots and indications
    // -----------------------------------------------------------------
    wire storeNow = (state_q == FWR_ST_STORE) & saveRec;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            wrSlot_q     <= 3'h0;
            recCount_q   <= 4'h0;
            wavesDeleted <= 1'b0;
            xferReq      <= 1'b0;
        end else begin
            wavesDeleted <= storeNow & slotFull;
            xferReq      <= storeNow & xferEn_q & (~xferTripOnly_q | sawTrip_q);
            if (storeNow) begin
                wrSlot_q <= wrSlot_q + 3'h1;
                if (!slotFull) begin
                    recCount_q <= recCount_q + 4'h1;
                end
            end
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            for (int i = 0; i < 8; i++) begin
                desc_q[i] <= 32'h0;
            end
        end else if (storeNow) begin
            desc_q[wrSlot_q] <= {wp_q, startAddr_q};
        end
    end
endmodule

// >>> tb/fwr_recorder_props.sv
// Purpose : port checks of the fault waveform recorder
// Assumes : one clock, resetn async active low
// Notes   : bound to every recorder instance
`timescale 1ns/10ps
module fwr_recorder_props #(
    parameter int SAMPLE_CYC = 4
) (
    input wire logic        clk,
    input wire logic        resetn,
    input wire logic [7:0]  paddr,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic [15:0] memAddr,
    input wire logic        memValid,
    input wire logic        memReady,
    input wire logic        recRunning,
    input wire logic        xferReq
);
    // ----------------------------------------------------------------
    // helpers and properties
    // ----------------------------------------------------------------
    localparam int RUN_MAX = SAMPLE_CYC * 128 * 501;
    logic [15:0] lastQ;
    logic        seenQ;
    int          runQ;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            lastQ <= 16'h0000;
            seenQ <= 1'b0;
            runQ  <= 0;
        end else begin
            lastQ <= (memValid && memReady) ? memAddr : lastQ;
            seenQ <= seenQ || (memValid && memReady);
            runQ  <= recRunning ? runQ + 1 : 0;
        end
    end
    a_reset_quiet: assert property ($rose(resetn) |-> !recRunning && !memValid && !pready)
        else $error("outputs active after reset");
    a_apb_answer: assert property (psel && !penable |=> pready) else $error("no apb answer");
    a_err_unmapped: assert property (pready |-> pslverr == (paddr > 8'h1C))
        else $error("slave error flag wrong");
    a_rdata_idle: assert property (!pready |-> prdata == 32'h0) else $error("read data not idle");
    a_mem_hold: assert property (memValid && !memReady |=> memValid) else $error("word lost");
    a_addr_step: assert property (memValid && memReady && seenQ |-> memAddr == lastQ + 16'h1)
        else $error("ring address skipped");
    a_xfer_pulse: assert property (xferReq |=> !xferReq) else $error("transfer request too long");
    a_run_bounded: assert property (runQ <= RUN_MAX) else $error("record too long");
    c_run: cover property ($rose(recRunning));
    c_xfer: cover property (xferReq);
    c_err: cover property (pready && pslverr);
endmodule
bind fwr_recorder fwr_recorder_props #(.SAMPLE_CYC(SAMPLE_CYC)) props_u (.clk(clk),
    .resetn(resetn), .paddr(paddr), .psel(psel), .penable(penable), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .memAddr(memAddr), .memValid(memValid),
    .memReady(memReady), .recRunning(recRunning), .xferReq(xferReq));

// >>> tb/fwr_ring_model.sv
// Purpose : ring memory on the sample write stream
// Assumes : one clock
// Notes   : stalls at most one cycle at a time
`timescale 1ns/10ps
module fwr_ring_model (
    input  wire logic clk,
    input  wire logic resetn,
    input  wire logic memValid,
    output logic      memReady,
    output int        wordCnt
);
    // ----------------------------------------------------------------
    // acceptance
    // ----------------------------------------------------------------
    initial memReady = 1'b0;
    initial wordCnt = 0;
    always @(posedge clk) begin
        memReady <= resetn && (!memReady || ($urandom % 2 == 1));
        if (memValid === 1'b1 && memReady) wordCnt <= wordCnt + 1;
    end
endmodule

// >>> tb/tb_fwr_recorder.sv
// Purpose : self-checking bench of the fault waveform recorder
// Assumes : four-clock sample period
// Notes   : apb reads are checked from a queue
`timescale 1ns/10ps
module tb_fwr_recorder;
    // ----------------------------------------------------------------
    // stimulus and checks
    // ----------------------------------------------------------------
    localparam int SC = 4;
    localparam int U  = 8 * SC;
    logic        clk = 1'b0, resetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic        protPickup = 1'b0, protTrip = 1'b0, binTrigPin = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, ctrl;
    logic [15:0] sampleIn = 16'h0;
    logic        pready, pslverr, memValid, memReady, recRunning, wavesDeleted, xferReq;
    logic [32:0] e, m, expQ[$], mskQ[$];
    logic [31:0] dv [5] = '{32'h0, 32'h64, 32'h14, 32'h0A, 32'h32};
    logic [31:0] clv [8] = '{32'h043FF1F4, 32'h0400001E, 32'h083FF190, 32'h08000005,
                             32'h0C3FF032, 32'h0C000005, 32'h103FF1F4, 32'h10000000};
    int          err_total, comparisons, cyc, xfers, dels, runs;
    int          starts, runLen, lastLen, words, w, r;
    fwr_recorder #(.SAMPLE_CYC(SC)) dut_u (.clk(clk), .resetn(resetn), .paddr(paddr),
        .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .protPickup(protPickup), .protTrip(protTrip),
        .binTrigPin(binTrigPin), .sampleIn(sampleIn), .memAddr(), .memData(),
        .memValid(memValid), .memReady(memReady), .recRunning(recRunning),
        .wavesDeleted(wavesDeleted), .xferReq(xferReq));
    fwr_ring_model ring_u (.clk(clk), .resetn(resetn), .memValid(memValid),
        .memReady(memReady), .wordCnt(words));
    always #5 clk = ~clk;
    task automatic close_out();
        $display("comparisons %0d mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic cmp(input int g, lo, hi);
        comparisons++;
        if (g < lo || g > hi) begin
            err_total++;
            $display("wrong value at %0t got %h expected %h", $time, g, lo);
        end
    endtask
    always @(posedge clk) begin
        cyc <= cyc + 1;
        sampleIn <= 16'($urandom);
        xfers <= xfers + int'(xferReq === 1'b1);
        dels <= dels + int'(wavesDeleted === 1'b1);
        starts <= starts + int'(recRunning === 1'b1 && runLen == 0);
        runLen <= (recRunning === 1'b1) ? runLen + 1 : 0;
        if (recRunning !== 1'b1 && runLen > 0) begin
            lastLen <= runLen;
            runs <= runs + 1;
        end
        if (cyc == 30000) begin
            err_total = err_total + 1;
            close_out();
        end
    end
    always @(posedge clk) begin
        if (pready === 1'b1 && pwrite === 1'b0 && expQ.size() > 0) begin
            e = expQ.pop_front();
            m = mskQ.pop_front();
            comparisons++;
            if ((({pslverr, prdata} ^ e) & m) !== 33'h0) begin
                err_total++;
                $display("wrong value at %0t got %h expected %h", $time, {pslverr, prdata}, e);
            end
        end
    end
    task automatic apb(input logic [7:0] a, input logic wr, input logic [31:0] d,
                       input logic [32:0] ev, mv);
        @(posedge clk);
        paddr <= a;
        pwrite <= wr;
        pwdata <= d;
        psel <= 1'b1;
        if (!wr) begin
            expQ.push_back(ev);
            mskQ.push_back(mv);
        end
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic setc(input logic [31:0] c);
        ctrl = c;
        apb(8'h00, 1'b1, c, 33'h0, 33'h0);
    endtask
    // k: start, binary, trip, pickup; idle gap re-arms edges
    task automatic fire(input logic [3:0] k, input int n);
        if (k[3]) apb(8'h00, 1'b1, ctrl | 32'h100, 33'h0, 33'h0);
        repeat (8) @(posedge clk);
        {binTrigPin, protTrip, protPickup} <= k[2:0];
        repeat (n) @(posedge clk);
        {binTrigPin, protTrip, protPickup} <= 3'h0;
    endtask
    task automatic rec(input logic [3:0] k, input int n, len, u);
        r = runs;
        fire(k, n);
        while (runs == r) @(posedge clk);
        cmp(lastLen, len - u - 8, len + u + 8);
    endtask
    task automatic nrun(input logic [3:0] k, input int n);
        r = starts;
        fire(k, n);
        repeat (40) @(posedge clk);
        cmp(starts, r, r);
    endtask
    initial begin
        void'($urandom(32'h2C4E));
        repeat (2) @(posedge clk);
        resetn <= 1'b1;
        foreach (dv[i]) apb(8'(4 * i), 1'b0, 32'h0, {1'b0, dv[i]}, 33'h1FFFFFFFF);
        foreach (clv[i]) begin
            apb(clv[i][31:24], 1'b1, {20'h0, clv[i][23:12]}, 33'h0, 33'h0);
            apb(clv[i][31:24], 1'b0, 32'h0, {21'h0, clv[i][11:0]}, 33'h1FFFFFFFF);
        end
        apb(8'h20, 1'b0, 32'h0, 33'h100000000, 33'h1FFFFFFFF);
        for (int t = 0; t < 4; t += 3) begin
            setc(32'(t));
            nrun(4'h9, 30);
        end
        setc(32'h11);
        w = 50 + $urandom % 100;
        rec(4'h1, w, w + 5 * U, U);
        rec(4'h4, 2000, 30 * U, U);
        rec(4'h4, 100, 104 + 5 * U, U);
        apb(8'h10, 1'b1, 32'h0A, 33'h0, 33'h0);
        rec(4'h4, 4, 15 * U, U);
        rec(4'h8, 1, 15 * U, U);
        cmp(xfers, 5, 5);
        apb(8'h14, 1'b0, 32'h0, 33'h50, 33'hF0);
        r = words;
        repeat (320) @(posedge clk);
        cmp(words - r, 78, 82);
        setc(32'h12);
        r = words;
        repeat (320) @(posedge clk);
        cmp(words - r, 9, 11);
        rec(4'h8, 1, 15 * 16 * U, 16 * U);
        setc(32'h15);
        rec(4'h1, 50, 50 + 5 * U, U);
        setc(32'h19);
        nrun(4'h1, 50);
        rec(4'h2, 50, 50 + 5 * U, U);
        apb(8'h14, 1'b0, 32'h0, 33'h70, 33'hF0);
        setc(32'h31);
        rec(4'h1, 50, 50 + 5 * U, U);
        cmp(xfers, 7, 7);
        cmp(dels, 0, 0);
        rec(4'h3, 50, 50 + 5 * U, U);
        cmp(xfers, 8, 8);
        cmp(dels, 1, 1);
        apb(8'h14, 1'b0, 32'h0, 33'h80, 33'hF0);
        close_out();
    end
endmodule
